// *** hw/framer_pkg.sv ***
// Shared constants and types for the message framer
package framer_pkg;
  localparam int ALT_N = 15;
  localparam int ALT_W = 4;
  localparam int WORD_W = 16;
  localparam int ADDR_W = 16;
  localparam int CNT_W = 8;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CHK_INIT = 8'h00;
  localparam logic [15:0] OPERAND_SKIP = 16'h0001;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  typedef enum logic [1:0] {CHK_SUM = 2'b00, CHK_LRC = 2'b01, CHK_CRC = 2'b10} check_t;
  typedef enum logic [1:0] {FLD_CONST = 2'b00, FLD_WILD = 2'b01, FLD_WRITE = 2'b10} field_mode_t;
  typedef enum logic [1:0] {REF_OPERAND = 2'b00, REF_LINK = 2'b01, REF_DIRECT = 2'b10} ref_t;
  typedef enum logic [1:0] {PROC_END = 2'b00, PROC_GOTO = 2'b01, PROC_NEXT = 2'b10, PROC_ABORT = 2'b11} proc_t;
  typedef enum logic [3:0] {
    TX_IDLE = 4'b0000, TX_HDR = 4'b0001, TX_ADR = 4'b0010, TX_LEN = 4'b0011, TX_RD = 4'b0100,
    TX_RW1 = 4'b0101, TX_RW2 = 4'b0110, TX_DHI = 4'b0111, TX_DLO = 4'b1000, TX_CHK = 4'b1001,
    TX_TRM = 4'b1010
  } tx_state_t;
  typedef enum logic [2:0] {
    RX_HDR = 3'b000, RX_ADR = 3'b001, RX_LEN = 3'b010, RX_DAT = 3'b011, RX_CHK = 3'b100, RX_TRM = 3'b101
  } rx_state_t;
endpackage : framer_pkg

// *** hw/message_framer.sv ***
// Transmit framer and template-matching receive deframer
`timescale 1ns/1ps
`default_nettype none
// Function
// - Six fields: header, address, length, data, check, terminator
// - Length field filled with data byte count
// - Per-message SUM, LRC or CRC appended
// - Verify check code, take stated data length
// - Constant control characters in header, address, data and terminator
// - Wildcard address accepts any destination
// - Wildcard data accepts any content
// - Write-word address accepts and stores message
// - Write-word data accepts and stores message
// - Storage base is the third call operand
// - Operand read starts after second operand
// - Read from link area word plus offset
// - Read from direct word plus offset
// - Repeat index advances by one per repeat
// - First-order index expressions as word offsets
// - Up to 15 alternatives, matched one's processing
module message_framer (
  input wire logic clk,
  input wire logic resetn,
  input wire logic step_start,
  input wire logic step_repeat,
  input wire logic tx_start,
  input wire logic [7:0] tx_header,
  input wire logic [7:0] tx_addr_const,
  input wire logic [7:0] tx_addr_coef,
  input wire logic [6:0] tx_word_count,
  input wire framer_pkg::ref_t tx_ref,
  input wire logic [15:0] second_operand,
  input wire logic [15:0] third_operand,
  input wire logic [15:0] link_word,
  input wire logic [15:0] direct_word,
  input wire logic [15:0] offset_coef,
  input wire logic [15:0] offset_const,
  input wire framer_pkg::check_t tx_check,
  input wire logic [7:0] tx_terminator,
  output logic tx_valid,
  output logic [7:0] tx_byte,
  input wire logic tx_ready,
  output logic tx_done,
  output logic exec_busy,
  output logic [15:0] mem_addr,
  output logic mem_rd,
  output logic mem_we,
  output logic [15:0] mem_wdata,
  input wire logic [15:0] mem_rdata,
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  input wire framer_pkg::check_t rx_check,
  input wire logic [14:0] alt_enable,
  input wire logic [119:0] alt_header,
  input wire logic [119:0] alt_addr,
  input wire logic [29:0] alt_addr_mode,
  input wire logic [29:0] alt_data_mode,
  input wire logic [119:0] alt_data_const,
  input wire logic [119:0] alt_terminator,
  input wire logic [29:0] alt_next_proc,
  input wire logic [29:0] alt_err_proc,
  output logic rx_done,
  output logic rx_error,
  output logic [3:0] rx_alt,
  output logic [1:0] rx_next_proc,
  output logic [1:0] rx_err_proc,
  output logic [7:0] rx_len,
  output logic [7:0] repeat_index
);
  import framer_pkg::*;

  function automatic logic [7:0] chk_step(input check_t m, input logic [7:0] acc, input logic [7:0] b);
    logic [7:0] c;
    c = acc ^ b;
    unique case (m)
      CHK_SUM: c = acc + b;
      CHK_LRC: c = acc ^ b;
      default: begin
        for (int i = 0; i < 8; i++) begin
          c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
        end
      end
    endcase
    return c;
  endfunction : chk_step

  logic rst_stage, rst_n;
  tx_state_t tx_state;
  rx_state_t rx_state;
  logic [6:0] tx_left;
  logic [15:0] tx_word, tx_ptr, rx_widx, rx_wword, rx_waddr, word_off, rd_base;
  logic [7:0] tx_acc, rx_acc, rx_left, rx_hi, tx_cur;
  logic [14:0] alive, next_alive;
  logic rx_store, rx_hi_held, rx_wpend, any_alive;
  logic [3:0] first_alive;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      {rst_stage, rst_n} <= 2'b00;
    end else begin
      {rst_stage, rst_n} <= {1'b1, rst_stage};
    end
  end
  // Repeat index
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      repeat_index <= 8'h00;
    end else if (step_start) begin
      repeat_index <= 8'h00;
    end else if (step_repeat) begin
      repeat_index <= repeat_index + 8'h01;
    end
  end

  // Word address resolution
  always_comb begin
    word_off = 16'(offset_coef * {8'h00, repeat_index}) + offset_const;
    unique case (tx_ref)
      REF_OPERAND: rd_base = second_operand + OPERAND_SKIP;
      REF_LINK: rd_base = link_word;
      default: rd_base = direct_word;
    endcase
  end

  always_comb begin
    unique case (tx_state)
      TX_HDR: tx_cur = tx_header;
      TX_ADR: tx_cur = 8'(tx_addr_const + tx_addr_coef * repeat_index);
      TX_LEN: tx_cur = {tx_word_count, 1'b0};
      TX_DHI: tx_cur = tx_word[15:8];
      TX_DLO: tx_cur = tx_word[7:0];
      TX_CHK: tx_cur = tx_acc;
      default: tx_cur = tx_terminator;
    endcase
  end

  // Transmit framer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_state <= TX_IDLE;
      {tx_valid, tx_done} <= 2'b00;
      tx_byte <= 8'h00;
      tx_left <= 7'h00;
      {tx_word, tx_ptr} <= 32'h00000000;
      tx_acc <= CHK_INIT;
    end else begin
      tx_done <= 1'b0;
      unique case (tx_state)
        TX_IDLE: begin
          if (tx_start && !exec_busy) begin
            tx_state <= TX_HDR;
            tx_acc <= CHK_INIT;
            tx_left <= tx_word_count;
            tx_ptr <= rd_base + word_off;
          end
        end
        TX_RD: begin
          if (!rx_wpend) begin
            tx_state <= TX_RW1;
          end
        end
        TX_RW1: tx_state <= TX_RW2;
        TX_RW2: begin
          tx_word <= mem_rdata;
          tx_ptr <= tx_ptr + 16'h0001;
          tx_left <= tx_left - 7'h01;
          tx_state <= TX_DHI;
        end
        default: begin
          if (!tx_valid) begin
            tx_valid <= 1'b1;
            tx_byte <= tx_cur;
          end else if (tx_ready) begin
            tx_valid <= 1'b0;
            if (tx_state != TX_HDR && tx_state != TX_CHK && tx_state != TX_TRM) begin
              tx_acc <= chk_step(tx_check, tx_acc, tx_byte);
            end
            unique case (tx_state)
              TX_HDR: tx_state <= TX_ADR;
              TX_ADR: tx_state <= TX_LEN;
              TX_LEN: tx_state <= (tx_left == 7'h00) ? TX_CHK : TX_RD;
              TX_DHI: tx_state <= TX_DLO;
              TX_DLO: tx_state <= (tx_left == 7'h00) ? TX_CHK : TX_RD;
              TX_CHK: tx_state <= TX_TRM;
              default: begin
                tx_state <= TX_IDLE;
                tx_done <= 1'b1;
              end
            endcase
          end
        end
      endcase
    end
  end

  // Template comparison for the current byte
  always_comb begin
    next_alive = alive;
    for (int a = 0; a < ALT_N; a++) begin
      unique case (rx_state)
        RX_HDR: next_alive[a] = alt_enable[a] && (rx_byte == alt_header[a*8 +: 8]);
        RX_ADR: begin
          if (alt_addr_mode[a*2 +: 2] == FLD_CONST && rx_byte != alt_addr[a*8 +: 8]) begin
            next_alive[a] = 1'b0;
          end
        end
        RX_DAT: begin
          if (alt_data_mode[a*2 +: 2] == FLD_CONST && rx_byte != alt_data_const[a*8 +: 8]) begin
            next_alive[a] = 1'b0;
          end
        end
        RX_TRM: begin
          if (rx_byte != alt_terminator[a*8 +: 8]) begin
            next_alive[a] = 1'b0;
          end
        end
        default: next_alive[a] = alive[a];
      endcase
    end
    first_alive = 4'h0;
    any_alive = 1'b0;
    for (int a = ALT_N - 1; a >= 0; a--) begin
      if (next_alive[a]) begin
        first_alive = 4'(a);
        any_alive = 1'b1;
      end
    end
  end

  // Receive deframer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_state <= RX_HDR;
      alive <= 15'h0000;
      rx_acc <= CHK_INIT;
      {rx_left, rx_len, rx_hi} <= 24'h000000;
      {rx_store, rx_hi_held, rx_wpend, rx_done, rx_error} <= 5'h00;
      {rx_widx, rx_wword, rx_waddr} <= 48'h000000000000;
      rx_alt <= 4'h0;
      {rx_next_proc, rx_err_proc} <= 4'h0;
    end else begin
      {rx_done, rx_error, rx_wpend} <= 3'b000;
      if (rx_valid) begin
        alive <= next_alive;
        if (rx_state != RX_HDR && rx_state != RX_CHK && rx_state != RX_TRM) begin
          rx_acc <= chk_step(rx_check, rx_acc, rx_byte);
        end
        unique case (rx_state)
          RX_HDR: begin
            rx_acc <= CHK_INIT;
            {rx_store, rx_hi_held} <= 2'b00;
            rx_widx <= 16'h0000;
            if (any_alive) begin
              rx_state <= RX_ADR;
            end else begin
              rx_error <= 1'b1;
              rx_err_proc <= alt_err_proc[1:0];
            end
          end
          RX_ADR: begin
            for (int a = 0; a < ALT_N; a++) begin
              if (next_alive[a] && (alt_addr_mode[a*2 +: 2] == FLD_WRITE || alt_data_mode[a*2 +: 2] == FLD_WRITE)) begin
                rx_store <= 1'b1;
              end
            end
            rx_state <= RX_LEN;
          end
          RX_LEN: begin
            rx_len <= rx_byte;
            rx_left <= rx_byte;
            rx_state <= (rx_byte == BYTE_ZERO) ? RX_CHK : RX_DAT;
          end
          RX_DAT: begin
            rx_left <= rx_left - 8'h01;
            if (rx_store) begin
              if (rx_hi_held) begin
                rx_wpend <= 1'b1;
                rx_wword <= {rx_hi, rx_byte};
                rx_waddr <= third_operand + rx_widx;
                rx_widx <= rx_widx + 16'h0001;
              end
              rx_hi <= rx_byte;
              rx_hi_held <= !rx_hi_held;
            end
            if (rx_left == 8'h01) begin
              rx_state <= RX_CHK;
            end
          end
          RX_CHK: begin
            if (rx_byte != rx_acc) begin
              alive <= 15'h0000;
            end
            if (rx_store && rx_hi_held) begin
              rx_wpend <= 1'b1;
              rx_wword <= {rx_hi, BYTE_ZERO};
              rx_waddr <= third_operand + rx_widx;
              rx_hi_held <= 1'b0;
            end
            rx_state <= RX_TRM;
          end
          default: begin
            rx_state <= RX_HDR;
            if (any_alive) begin
              rx_done <= 1'b1;
              rx_alt <= first_alive;
              rx_next_proc <= alt_next_proc[first_alive*2 +: 2];
              rx_err_proc <= alt_err_proc[first_alive*2 +: 2];
            end else begin
              rx_error <= 1'b1;
              rx_err_proc <= alt_err_proc[1:0];
            end
          end
        endcase
      end
    end
  end
  // Shared data-area port, receive writes first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {mem_addr, mem_wdata} <= 32'h00000000;
      {mem_rd, mem_we, exec_busy} <= 3'b000;
    end else begin
      {mem_rd, mem_we} <= 2'b00;
      exec_busy <= (tx_state != TX_IDLE) || (tx_start && !exec_busy);
      if (rx_wpend) begin
        mem_we <= 1'b1;
        mem_addr <= rx_waddr;
        mem_wdata <= rx_wword;
      end else if (tx_state == TX_RD) begin
        mem_rd <= 1'b1;
        mem_addr <= tx_ptr;
      end
    end
  end
endmodule : message_framer
`default_nettype wire

// *** tb/framer_checker_assertions.sv ***
// Port assertions for the framer
`timescale 1ns/1ps
`default_nettype none
module framer_checker (
  input wire logic clk,
  input wire logic resetn,
  input wire logic step_start,
  input wire logic step_repeat,
  input wire logic tx_start,
  input wire logic [7:0] tx_header,
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  input wire logic tx_ready,
  input wire logic tx_done,
  input wire logic exec_busy,
  input wire logic rx_done,
  input wire logic rx_error,
  input wire logic [7:0] repeat_index
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_busy; tx_start && !exec_busy |-> ##2 exec_busy; endproperty
  a_busy: assert property (p_busy) else $error("busy late");
  property p_head; tx_start && !exec_busy |-> ##[2:3] tx_valid && tx_byte == tx_header; endproperty
  a_head: assert property (p_head) else $error("bad first byte");
  property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte); endproperty
  a_hold: assert property (p_hold) else $error("byte lost");
  property p_gap; tx_valid && tx_ready |=> !tx_valid; endproperty
  a_gap: assert property (p_gap) else $error("no gap");
  property p_done; tx_done |=> !tx_done; endproperty
  a_done: assert property (p_done) else $error("done long");
  property p_rx; !(rx_done && rx_error); endproperty
  a_rx: assert property (p_rx) else $error("done and error");
  property p_inc; step_repeat && !step_start |=> repeat_index == $past(repeat_index) + 8'h01; endproperty
  a_inc: assert property (p_inc) else $error("index stuck");
  property p_clr; step_start |=> repeat_index == 8'h00; endproperty
  a_clr: assert property (p_clr) else $error("index kept");
  c_tx: cover property (tx_done);
  c_rx: cover property (rx_done);
  c_err: cover property (rx_error);
endmodule : framer_checker
bind message_framer framer_checker chk (
  .clk(clk),
  .resetn(resetn),
  .step_start(step_start),
  .step_repeat(step_repeat),
  .tx_start(tx_start),
  .tx_header(tx_header),
  .tx_valid(tx_valid),
  .tx_byte(tx_byte),
  .tx_ready(tx_ready),
  .tx_done(tx_done),
  .exec_busy(exec_busy),
  .rx_done(rx_done),
  .rx_error(rx_error),
  .repeat_index(repeat_index)
);
`default_nettype wire

// *** tb/serial_peer.sv ***
// Line-side peer: stalling sink and byte source
`timescale 1ns/1ps
`default_nettype none
module serial_peer (
  input wire logic clk,
  input wire logic slow,
  output logic tx_ready,
  output logic rx_valid,
  output logic [7:0] rx_byte
);
  initial {tx_ready, rx_valid, rx_byte} = '0;
  // Ready each cycle, or every other one when slow
  always @(posedge clk) tx_ready <= !slow || !tx_ready;
  task send(input logic [7:0] b);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_byte <= b;
  endtask : send
  task idle();
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_byte <= ~rx_byte;
  endtask : idle
endmodule : serial_peer
`default_nettype wire

// *** tb/tb_top.sv ***
// Framer bench
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import framer_pkg::*;
  logic clk, resetn, step_start, step_repeat, tx_start, tx_ready, tx_valid, tx_done, exec_busy, slow, mem_rd;
  logic mem_we, rx_valid, rx_done, rx_error;
  logic [7:0] tx_header, tx_addr_const, tx_addr_coef, tx_terminator, tx_byte, rx_byte, rx_len, repeat_index;
  logic [15:0] second_operand, third_operand, link_word, direct_word, offset_coef, offset_const;
  logic [15:0] mem_addr, mem_wdata, mem_rdata;
  logic [119:0] alt_header, alt_addr, alt_data_const, alt_terminator;
  logic [29:0] alt_addr_mode, alt_data_mode, alt_next_proc, alt_err_proc;
  logic [14:0] alt_enable;
  logic [6:0] tx_word_count;
  logic [3:0] rx_alt;
  logic [1:0] rx_next_proc, rx_err_proc;
  ref_t tx_ref;
  check_t tx_check, rx_check;
  logic [7:0] eq[$];
  logic [5:0] rq[$];
  logic [31:0] wq[$];
  int miscompares, checks, seed;
  message_framer DUT (
    .clk(clk),
    .resetn(resetn),
    .step_start(step_start),
    .step_repeat(step_repeat),
    .tx_start(tx_start),
    .tx_header(tx_header),
    .tx_addr_const(tx_addr_const),
    .tx_addr_coef(tx_addr_coef),
    .tx_word_count(tx_word_count),
    .tx_ref(tx_ref),
    .second_operand(second_operand),
    .third_operand(third_operand),
    .link_word(link_word),
    .direct_word(direct_word),
    .offset_coef(offset_coef),
    .offset_const(offset_const),
    .tx_check(tx_check),
    .tx_terminator(tx_terminator),
    .tx_valid(tx_valid),
    .tx_byte(tx_byte),
    .tx_ready(tx_ready),
    .tx_done(tx_done),
    .exec_busy(exec_busy),
    .mem_addr(mem_addr),
    .mem_rd(mem_rd),
    .mem_we(mem_we),
    .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata),
    .rx_valid(rx_valid),
    .rx_byte(rx_byte),
    .rx_check(rx_check),
    .alt_enable(alt_enable),
    .alt_header(alt_header),
    .alt_addr(alt_addr),
    .alt_addr_mode(alt_addr_mode),
    .alt_data_mode(alt_data_mode),
    .alt_data_const(alt_data_const),
    .alt_terminator(alt_terminator),
    .alt_next_proc(alt_next_proc),
    .alt_err_proc(alt_err_proc),
    .rx_done(rx_done),
    .rx_error(rx_error),
    .rx_alt(rx_alt),
    .rx_next_proc(rx_next_proc),
    .rx_err_proc(rx_err_proc),
    .rx_len(rx_len),
    .repeat_index(repeat_index)
  );
  serial_peer peer (
    .clk(clk),
    .slow(slow),
    .tx_ready(tx_ready),
    .rx_valid(rx_valid),
    .rx_byte(rx_byte)
  );
  function automatic logic [7:0] ck(input logic [7:0] c, b, input int k);
    logic [7:0] r;
    r = k == 0 ? c + b : c ^ b;
    if (k == 2) repeat (8) r = r[7] ? {r[6:0], 1'b0} ^ 8'h07 : {r[6:0], 1'b0};
    return r;
  endfunction : ck
  task cmp(input logic [31:0] got, exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task end_sim();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim
  always @(posedge clk) begin
    if (tx_valid && tx_ready) cmp(tx_byte, eq.pop_front());
    if (rx_done) cmp({rx_alt, rx_next_proc, rx_len}, {rq.pop_front(), 8'h02});
    if (rx_error) cmp({4'hf, rx_err_proc}, rq.pop_front());
    if (mem_we) cmp({mem_addr, mem_wdata}, wq.pop_front());
    if (mem_rd) mem_rdata <= mem_addr ^ 16'h5a3c;
  end
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #600000;
    miscompares++;
    end_sim();
  end
  task set_n(input int n);
    @(posedge clk);
    {step_start, step_repeat} <= 2'b11;
    @(posedge clk);
    step_start <= 1'b0;
    step_repeat <= n > 0;
    repeat (n) @(posedge clk);
    if (n > 0) step_repeat <= 1'b0;
  endtask : set_n
  task tx_frame(input int k, n);
    logic [15:0] a, w;
    logic [7:0] b, c;
    int m;
    m = {$random(seed)} % 6;
    set_n(m);
    @(posedge clk);
    tx_check <= check_t'(k);
    tx_ref <= ref_t'(k);
    tx_word_count <= 7'(n);
    slow <= k[0];
    #1;
    a = k == 0 ? second_operand + 16'h0001 : k == 1 ? link_word : direct_word;
    a = a + offset_coef * 16'(m) + offset_const;
    b = tx_addr_const + tx_addr_coef * 8'(m);
    c = ck(ck(8'h00, b, k), 8'(2 * n), k);
    eq = {tx_header, b, 8'(2 * n)};
    for (int i = 0; i < n; i++) begin
      w = (a + 16'(i)) ^ 16'h5a3c;
      eq.push_back(w[15:8]);
      eq.push_back(w[7:0]);
      c = ck(ck(c, w[15:8], k), w[7:0], k);
    end
    eq.push_back(c);
    eq.push_back(tx_terminator);
    @(posedge clk);
    tx_start <= exec_busy !== 1'b1;
    @(posedge clk);
    tx_start <= 1'b0;
    for (int t = 0; t < 4000 && tx_done !== 1'b1; t++) @(posedge clk) #1;
    cmp(eq.size(), 0);
    $display("tx test %0d done", k);
  endtask : tx_frame
  task rx_frame(input logic [7:0] h, a, input logic bad, input int k, input logic [5:0] e);
    logic [7:0] d0, d1, c, f[7];
    d0 = 8'($random(seed));
    d1 = 8'($random(seed));
    c = ck(ck(ck(ck(8'h00, a, k), 8'h02, k), d0, k), d1, k) ^ 8'(bad);
    f = '{h, a, 8'h02, d0, d1, c, 8'h0d};
    rq.push_back(e);
    if (h == 8'h3a) wq.push_back({third_operand, d0, d1});
    @(posedge clk);
    rx_check <= check_t'(k);
    foreach (f[i]) peer.send(f[i]);
    peer.idle();
  endtask : rx_frame
  initial begin
    seed = 32'h5532;
    {resetn, step_start, step_repeat, tx_start, slow, tx_word_count, mem_rdata} = '0;
    tx_ref = REF_OPERAND;
    tx_check = CHK_SUM;
    rx_check = CHK_SUM;
    tx_header = 8'h02;
    tx_terminator = 8'h0d;
    {second_operand, link_word, direct_word, offset_coef} = {$random(seed), $random(seed)};
    {offset_const, third_operand} = $random(seed);
    {tx_addr_const, tx_addr_coef} = 16'($random(seed));
    alt_enable = 15'h4009;
    alt_header = {8'h3b, 80'h0, 8'h3a, 16'h0, 8'h02};
    alt_addr = 120'h11;
    alt_data_const = '0;
    alt_terminator = {15{8'h0d}};
    alt_addr_mode = {2'h1, 20'h0, 2'h2, 6'h00};
    alt_data_mode = {2'h1, 20'h0, 2'h2, 6'h01};
    alt_next_proc = {22'h0, 2'h2, 6'h01};
    alt_err_proc = 30'h3;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    for (int k = 0; k < 3; k++) tx_frame(k, k == 2 ? 127 : k + 1);
    for (int k = 0; k < 3; k++) begin
      rx_frame(8'h02, 8'h11, 1'b0, k, {4'h0, 2'h1});
      rx_frame(8'h3a, 8'($random(seed)), 1'b0, k, {4'h3, 2'h2});
      rx_frame(8'h3b, 8'($random(seed)), 1'b0, k, {4'he, 2'h0});
      rx_frame(8'h02, 8'h11, 1'b1, k, {4'hf, 2'h3});
      $display("rx test %0d done", k);
    end
    rq.push_back({4'hf, 2'h3});
    peer.send(8'h55);
    peer.idle();
    repeat (20) @(posedge clk);
    cmp(rq.size() + wq.size(), 0);
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
